// *** pkg/ssp_pkg.sv ***
package ssp_pkg;
  // What this block does
  // - Top control bits select mode and variant.
  // - Async frames: start, 8/9 data, stop.
  // - Mode 1 variant needs valid stop bit.
  // - Mode 2 64/32 clocks; mode 3 timer.
  // - Multiprocessor: ninth bit zero, no flag.
  // - Bit timing clock stops during idle.
  // - Modes 1/3 pick timer 1 or 2.
  // - Receive enable gates and starts reception.
  // - Transmit ninth-bit control sent in modes 2/3.
  // - Received ninth bit or stop stored.
  // - Mode 0 leaves received ninth bit alone.
  // - Transmit flag set after last data bit.
  // - Receive flag: mode 0 bit 8, mode 1 stop.
  // - Modes 2/3 flag after ninth-bit sample.
  // - Data address: write transmit, read receive.
  // - Rate-double bit doubles the mode 2 and timer 1 baud rates.

  // Register offsets
  localparam logic [7:0] A_CTRL = 8'hc0;
  localparam logic [7:0] A_DATA = 8'hc1;
  localparam logic [7:0] A_TIMING = 8'hc2;
  localparam logic [7:0] A_IST = 8'hc3;
  localparam logic [7:0] A_IMASK = 8'hc4;

  // Control fields
  localparam int C_MODE_HI = 7;
  localparam int C_VARIANT = 5;
  localparam int C_REN = 4;
  localparam int C_TB8 = 3;
  localparam int C_RB8 = 2;
  localparam int C_TI = 1;
  localparam int C_RI = 0;

  // Timing fields
  localparam int T_DOUBLE = 0;
  localparam int T_RX_T2 = 1;
  localparam int T_TX_T2 = 2;

  // Interrupt fields
  localparam int I_RX = 0;
  localparam int I_TX = 1;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] TIMING_RST = 3'h0;
  localparam logic [1:0] IMASK_RST = 2'h0;

  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE1 = 2'h1;

  // Bit periods in peripheral clocks
  localparam logic [6:0] M0_SLOW = 7'h0c;
  localparam logic [6:0] M0_FAST = 7'h04;
  localparam logic [6:0] M2_SLOW = 7'h40;
  localparam logic [6:0] M2_FAST = 7'h20;
  localparam logic [6:0] OVS = 7'h10;
  localparam logic [5:0] M2_SLOW_DIV = 6'(M2_SLOW / OVS - 7'h01);
  localparam logic [5:0] M2_FAST_DIV = 6'(M2_FAST / OVS - 7'h01);

  // Oversample tick positions
  localparam logic [3:0] TK_LAST = 4'hf;
  localparam logic [3:0] TK_S0 = 4'h7;
  localparam logic [3:0] TK_S1 = 4'h8;
  localparam logic [3:0] TK_S2 = 4'h9;
  localparam logic [3:0] BIT7 = 4'h7;
  localparam logic [3:0] BIT8 = 4'h8;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_START = 2'h1,
    PH_DATA = 2'h3,
    PH_STOP = 2'h2
  } ssp_phase_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ssp_req_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rbuf;
    logic [2:0] timing;
    logic [1:0] ist;
    logic [1:0] imask;
    logic [7:0] rdata;
    logic t1_half;
    logic [5:0] m2_div;
    ssp_phase_e tx_ph;
    logic [8:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_tick;
    logic [6:0] m0_div;
    logic m0_rx;
    logic txd;
    logic rxd_o;
    logic rxd_oe;
    ssp_phase_e rx_ph;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [3:0] rx_tick;
    logic [1:0] rx_smp;
    logic rx_prev;
  } ssp_state_s;

  localparam ssp_state_s STATE_RST = '{
    ctrl: CTRL_RST,
    rbuf: DATA_RST,
    timing: TIMING_RST,
    imask: IMASK_RST,
    tx_ph: PH_IDLE,
    rx_ph: PH_IDLE,
    txd: 1'b1,
    rx_prev: 1'b1,
    default: '0
  };
endpackage

// *** logic/ssp_core.sv ***
`timescale 1ns/1ps
module ssp_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire ssp_pkg::ssp_req_s bus_req,
  output logic [7:0] reg_rdata,
  // Timing sources
  input wire logic idle_mode,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  // Serial line
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  // Interrupt
  output logic irq
);
  ssp_pkg::ssp_state_s s_q;
  ssp_pkg::ssp_state_s s_d;

  logic [1:0] mode;
  logic variant;
  logic ren;
  logic dbl;
  logic pen;
  logic t1_tk;
  logic m2_tk;
  logic tx_tk;
  logic rx_tk;
  logic [6:0] m0_per;
  logic [6:0] m0_half;
  logic [3:0] tx_last;
  logic rx_v;
  logic data_wr;
  logic tx_set;
  logic rx_set;
  logic [6:0] m0_next;

  assign mode = s_q.ctrl[ssp_pkg::C_MODE_HI -: 2];
  assign variant = s_q.ctrl[ssp_pkg::C_VARIANT];
  assign ren = s_q.ctrl[ssp_pkg::C_REN];
  assign dbl = s_q.timing[ssp_pkg::T_DOUBLE];

  // Peripheral clock enable follows the core clock but halts in idle
  assign pen = !idle_mode;

  // Timer 1 overflow halved unless doubled, giving the 16x tick
  assign t1_tk = pen && timer1_ovf && (dbl || s_q.t1_half);
  // At-or-above compare, so a rate change mid-count cannot run the prescaler round its width
  assign m2_tk = pen && (s_q.m2_div >= (dbl ? ssp_pkg::M2_FAST_DIV
                                            : ssp_pkg::M2_SLOW_DIV));

  assign tx_tk = mode[1] && !mode[0] ? m2_tk
               : s_q.timing[ssp_pkg::T_TX_T2] ? (pen && timer2_ovf) : t1_tk;
  assign rx_tk = mode[1] && !mode[0] ? m2_tk
               : s_q.timing[ssp_pkg::T_RX_T2] ? (pen && timer2_ovf) : t1_tk;

  assign m0_per = variant ? ssp_pkg::M0_FAST : ssp_pkg::M0_SLOW;
  assign m0_half = m0_per >> 1;
  assign m0_next = (s_q.m0_div >= m0_per - 7'h01) ? 7'h00 : s_q.m0_div + 7'h01;

  // Ninth data bit only in modes 2 and 3
  assign tx_last = mode[1] ? ssp_pkg::BIT8 : ssp_pkg::BIT7;

  // Majority of three samples around mid-bit
  assign rx_v = (s_q.rx_smp[0] & s_q.rx_smp[1]) | (s_q.rx_smp[0] & rxd_in)
              | (s_q.rx_smp[1] & rxd_in);

  always_comb begin
    s_d = s_q;
    tx_set = 1'b0;
    rx_set = 1'b0;
    data_wr = 1'b0;
    s_d.rdata = 8'h00;
    s_d.rx_prev = rxd_in;

    // Register reads
    if (bus_req.rd) begin
      case (bus_req.addr)
        ssp_pkg::A_CTRL: s_d.rdata = s_q.ctrl;
        ssp_pkg::A_DATA: s_d.rdata = s_q.rbuf;
        ssp_pkg::A_TIMING: s_d.rdata = {5'h00, s_q.timing};
        ssp_pkg::A_IST: s_d.rdata = {6'h00, s_q.ist};
        ssp_pkg::A_IMASK: s_d.rdata = {6'h00, s_q.imask};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // Register writes; hardware sets below override a same-cycle clear
    if (bus_req.wr) begin
      case (bus_req.addr)
        ssp_pkg::A_CTRL: s_d.ctrl = bus_req.wdata;
        ssp_pkg::A_DATA: data_wr = 1'b1;
        ssp_pkg::A_TIMING: s_d.timing = bus_req.wdata[2:0];
        ssp_pkg::A_IST: s_d.ist = s_q.ist & ~bus_req.wdata[1:0];
        ssp_pkg::A_IMASK: s_d.imask = bus_req.wdata[1:0];
        default: ;
      endcase
    end

    // Baud prescalers
    if (pen) begin
      s_d.m2_div = m2_tk ? 6'h00 : s_q.m2_div + 6'h01;
      if (timer1_ovf) begin
        s_d.t1_half = !s_q.t1_half;
      end
    end

    // Transmitter, also the mode 0 shift engine for both directions
    case (s_q.tx_ph)
      ssp_pkg::PH_IDLE: begin
        s_d.tx_cnt = 4'h0;
        s_d.tx_tick = 4'h0;
        s_d.m0_div = 7'h00;
        if (data_wr) begin
          s_d.tx_sh = {s_q.ctrl[ssp_pkg::C_TB8], bus_req.wdata};
          s_d.m0_rx = 1'b0;
          if (mode == ssp_pkg::MODE0) begin
            s_d.tx_ph = ssp_pkg::PH_DATA;
            s_d.rxd_o = bus_req.wdata[0];
            s_d.rxd_oe = 1'b1;
            s_d.txd = 1'b0;
          end else begin
            s_d.tx_ph = ssp_pkg::PH_START;
            s_d.txd = 1'b0;
          end
        end else if (mode == ssp_pkg::MODE0 && ren && !s_q.ctrl[ssp_pkg::C_RI]) begin
          // Setting the enable launches one synchronous receive
          s_d.tx_ph = ssp_pkg::PH_DATA;
          s_d.m0_rx = 1'b1;
          s_d.txd = 1'b0;
        end
      end
      ssp_pkg::PH_START: begin
        if (tx_tk) begin
          s_d.tx_tick = s_q.tx_tick + 4'h1;
          if (s_q.tx_tick == ssp_pkg::TK_LAST) begin
            s_d.tx_ph = ssp_pkg::PH_DATA;
            s_d.txd = s_q.tx_sh[0];
          end
        end
      end
      ssp_pkg::PH_DATA: begin
        if (mode == ssp_pkg::MODE0) begin
          if (pen) begin
            s_d.m0_div = m0_next;
            // Clock low for first half, data sampled at end of high half
            s_d.txd = (m0_next >= m0_half);
            if (m0_next == 7'h00) begin
              s_d.tx_sh = {rxd_in, s_q.tx_sh[8:1]};
              s_d.rxd_o = s_q.tx_sh[1];
              s_d.tx_cnt = s_q.tx_cnt + 4'h1;
              if (s_q.tx_cnt == ssp_pkg::BIT7) begin
                s_d.tx_ph = ssp_pkg::PH_IDLE;
                s_d.rxd_oe = 1'b0;
                s_d.txd = 1'b1;
                if (s_q.m0_rx) begin
                  // Ninth-bit status untouched here
                  s_d.rbuf = {rxd_in, s_q.tx_sh[8:2]};
                  rx_set = 1'b1;
                end else begin
                  tx_set = 1'b1;
                end
              end
            end
          end
        end else if (tx_tk) begin
          s_d.tx_tick = s_q.tx_tick + 4'h1;
          if (s_q.tx_tick == ssp_pkg::TK_LAST) begin
            if (s_q.tx_cnt == tx_last) begin
              s_d.tx_ph = ssp_pkg::PH_STOP;
              s_d.txd = 1'b1;
              tx_set = 1'b1;
            end else begin
              s_d.tx_cnt = s_q.tx_cnt + 4'h1;
              s_d.tx_sh = {1'b1, s_q.tx_sh[8:1]};
              s_d.txd = s_q.tx_sh[1];
            end
          end
        end
      end
      ssp_pkg::PH_STOP: begin
        if (tx_tk) begin
          s_d.tx_tick = s_q.tx_tick + 4'h1;
          if (s_q.tx_tick == ssp_pkg::TK_LAST) begin
            s_d.tx_ph = ssp_pkg::PH_IDLE;
          end
        end
      end
      default: s_d.tx_ph = ssp_pkg::PH_IDLE;
    endcase

    // Asynchronous receiver
    if (!ren || mode == ssp_pkg::MODE0) begin
      s_d.rx_ph = ssp_pkg::PH_IDLE;
    end else begin
      case (s_q.rx_ph)
        ssp_pkg::PH_IDLE: begin
          s_d.rx_tick = 4'h0;
          s_d.rx_cnt = 4'h0;
          if (s_q.rx_prev && !rxd_in) begin
            s_d.rx_ph = ssp_pkg::PH_START;
          end
        end
        ssp_pkg::PH_START, ssp_pkg::PH_DATA, ssp_pkg::PH_STOP: begin
          if (rx_tk) begin
            s_d.rx_tick = s_q.rx_tick + 4'h1;
            if (s_q.rx_tick == ssp_pkg::TK_S0) begin
              s_d.rx_smp[0] = rxd_in;
            end
            if (s_q.rx_tick == ssp_pkg::TK_S1) begin
              s_d.rx_smp[1] = rxd_in;
            end
            if (s_q.rx_tick == ssp_pkg::TK_S2) begin
              case (s_q.rx_ph)
                ssp_pkg::PH_START: begin
                  // A glitch that fails the start vote is dropped
                  if (rx_v) begin
                    s_d.rx_ph = ssp_pkg::PH_IDLE;
                  end
                end
                ssp_pkg::PH_DATA: begin
                  if (mode[1] && s_q.rx_cnt == ssp_pkg::BIT8) begin
                    // Done at the ninth-bit sample; stop bit not awaited
                    s_d.rx_ph = ssp_pkg::PH_IDLE;
                    if (!s_q.ctrl[ssp_pkg::C_RI] && (!variant || rx_v)) begin
                      s_d.rbuf = s_q.rx_sh[8:1];
                      s_d.ctrl[ssp_pkg::C_RB8] = rx_v;
                      rx_set = 1'b1;
                    end
                  end else begin
                    s_d.rx_sh = {rx_v, s_q.rx_sh[8:1]};
                    s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                  end
                end
                ssp_pkg::PH_STOP: begin
                  s_d.rx_ph = ssp_pkg::PH_IDLE;
                  if (!s_q.ctrl[ssp_pkg::C_RI] && (!variant || rx_v)) begin
                    s_d.rbuf = s_q.rx_sh[8:1];
                    s_d.ctrl[ssp_pkg::C_RB8] = rx_v;
                    rx_set = 1'b1;
                  end
                end
                default: ;
              endcase
            end
            if (s_q.rx_tick == ssp_pkg::TK_LAST) begin
              if (s_q.rx_ph == ssp_pkg::PH_START) begin
                s_d.rx_ph = ssp_pkg::PH_DATA;
              end else if (s_q.rx_ph == ssp_pkg::PH_DATA && !mode[1]
                           && s_q.rx_cnt == ssp_pkg::BIT8) begin
                s_d.rx_ph = ssp_pkg::PH_STOP;
              end
            end
          end
        end
        default: s_d.rx_ph = ssp_pkg::PH_IDLE;
      endcase
    end

    // Hardware only ever sets the flags, never clears them
    if (tx_set) begin
      s_d.ctrl[ssp_pkg::C_TI] = 1'b1;
      s_d.ist[ssp_pkg::I_TX] = 1'b1;
    end
    if (rx_set) begin
      s_d.ctrl[ssp_pkg::C_RI] = 1'b1;
      s_d.ist[ssp_pkg::I_RX] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= ssp_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign txd_out = s_q.txd;
  assign rxd_out = s_q.rxd_o;
  assign rxd_oe = s_q.rxd_oe;
  assign irq = |(s_q.ist & s_q.imask);
endmodule

// *** tb/ssp_core_sva.sv ***
`timescale 1ns/1ps
module ssp_core_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire ssp_pkg::ssp_req_s bus_req,
  input wire logic [7:0] reg_rdata,
  // Timing and line
  input wire logic idle_mode,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] ctrl_q, wd_q;
  logic [1:0] msk_q;
  logic dbl_q, m2_q, tb8_q;
  logic [10:0] cnt_q;
  wire w = bus_req.wr;
  wire [7:0] a = bus_req.addr;
  // Frame window counted only from an idle start
  wire go = w && a == ssp_pkg::A_DATA && cnt_q == 11'h000;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 8'h00;
      wd_q <= 8'h00;
      msk_q <= 2'h0;
      dbl_q <= 1'b0;
      m2_q <= 1'b0;
      tb8_q <= 1'b0;
      cnt_q <= 11'h000;
    end else begin
      if (w && a == ssp_pkg::A_CTRL) ctrl_q <= bus_req.wdata;
      if (w && a == ssp_pkg::A_IMASK) msk_q <= bus_req.wdata[1:0];
      if (w && a == ssp_pkg::A_TIMING) dbl_q <= bus_req.wdata[0];
      if (go) begin
        wd_q <= bus_req.wdata;
        m2_q <= ctrl_q[7:6] == 2'h2 && !dbl_q;
        tb8_q <= ctrl_q[3];
      end
      if (go) cnt_q <= 11'h001;
      else if (cnt_q != 11'h000 && cnt_q < 11'h2c0) cnt_q <= cnt_q + 11'h001;
      else cnt_q <= 11'h000;
    end
  end
  sequence s_go2; go && ctrl_q[7:6] == 2'h2 && !dbl_q; endsequence
  sequence s_go0; go && ctrl_q[7:5] == 3'h0; endsequence
  property p_rdata; !bus_req.rd |=> reg_rdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data not zero");
  property p_head; s_go2 |-> ##32 !txd_out ##64 txd_out == wd_q[0] ##64 txd_out == wd_q[1];
  endproperty
  a_head: assert property (p_head) else $error("start or first bits wrong");
  property p_last; cnt_q == 11'h220 && m2_q |-> txd_out == wd_q[7]; endproperty
  a_last: assert property (p_last) else $error("last data bit wrong");
  property p_ninth; cnt_q == 11'h260 && m2_q |-> txd_out == tb8_q; endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit wrong");
  property p_stop; cnt_q == 11'h2a0 && m2_q |-> txd_out; endproperty
  a_stop: assert property (p_stop) else $error("stop bit low");
  property p_m0; s_go0 |-> ##3 !txd_out && rxd_oe ##6 txd_out; endproperty
  a_m0: assert property (p_m0) else $error("sync clock wrong");
  property p_oe; rxd_oe |-> ctrl_q[7:6] == 2'h0; endproperty
  a_oe: assert property (p_oe) else $error("data pin driven outside mode 0");
  property p_irq; irq |-> msk_q != 2'h0 || $past(msk_q) != 2'h0; endproperty
  a_irq: assert property (p_irq) else $error("irq while all masked");
endmodule
bind ssp_core ssp_core_sva u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .reg_rdata(reg_rdata),
  .idle_mode(idle_mode), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
  .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq)
);

// *** tb/ssp_remote.sv ***
`timescale 1ns/1ps
module ssp_remote (
  // Clock
  input wire logic sys_clk,
  // Line
  input wire logic txd_out,
  output logic rxd_in
);
  // Idle line high, as with a pull-up
  initial rxd_in = 1'b1;
  // Start, bits LSB first, stop; bt cycles a bit
  task automatic send(input logic [8:0] f, input int nb, input int bt);
    rxd_in <= 1'b0;
    repeat (bt) @(posedge sys_clk);
    for (int i = 0; i < nb; i++) begin
      rxd_in <= f[i];
      repeat (bt) @(posedge sys_clk);
    end
    rxd_in <= 1'b1;
    repeat (bt) @(posedge sys_clk);
  endtask
  // Mid-bit sampling; ok drops on a bad start or stop
  task automatic recv(input int nb, input int bt, output logic [8:0] f, output logic ok);
    int n;
    n = 0;
    f = 9'h000;
    while (txd_out !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (bt / 2) @(posedge sys_clk);
    ok = txd_out === 1'b0;
    for (int i = 0; i < nb; i++) begin
      repeat (bt) @(posedge sys_clk);
      f[i] = txd_out;
    end
    repeat (bt) @(posedge sys_clk);
    ok = ok && txd_out === 1'b1;
  endtask
  // Sync receive partner: next bit on each rising shift clock, idle high after
  task automatic shift(input logic [7:0] d, input int bt);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_out);
      rxd_in <= d[i];
    end
    repeat (bt) @(posedge sys_clk);
    rxd_in <= 1'b1;
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("BAD %s exp %h got %h", nm, exp, got); \
    end \
  end
module testbench;
  logic sys_clk, rst_n, tk, idle, rxd_in, rxd_out, rxd_oe, txd_out, irq;
  ssp_pkg::ssp_req_s req;
  logic [7:0] rdata;
  int err_total, total_checks;
  always #50 sys_clk = ~sys_clk;
  // Overflow pulse every second cycle
  always @(posedge sys_clk) tk <= ~tk;
  ssp_core dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(req), .reg_rdata(rdata),
    .idle_mode(idle), .timer1_ovf(tk), .timer2_ovf(tk), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq)
  );
  ssp_remote rem (.sys_clk(sys_clk), .txd_out(txd_out), .rxd_in(rxd_in));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req <= '0;
    // Read data taken mid-cycle, clear of the edge that retires it
    @(negedge sys_clk);
    `CHK(nm, e, rdata)
    @(posedge sys_clk);
  endtask
  task automatic rxc(input logic [7:0] tm, c, input logic [8:0] f, input int nb, bt,
                     input logic [7:0] ec, ed);
    wr(ssp_pkg::A_TIMING, tm);
    wr(ssp_pkg::A_CTRL, c);
    rem.send(f, nb, bt);
    rc(ssp_pkg::A_CTRL, ec, "rx ctrl");
    rc(ssp_pkg::A_DATA, ed, "rx data");
  endtask
  task automatic t_reset;
    rc(ssp_pkg::A_CTRL, 8'h00, "ctrl rst");
    rc(ssp_pkg::A_DATA, 8'h00, "data rst");
    rc(8'hc7, 8'h00, "unmapped");
  endtask
  task automatic t_tx2;
    logic [8:0] v;
    logic ok;
    wr(ssp_pkg::A_IMASK, 8'h02);
    wr(ssp_pkg::A_CTRL, 8'h88);
    fork
      rem.recv(9, 64, v, ok);
      wr(ssp_pkg::A_DATA, 8'ha5);
    join
    `CHK("tx frame", 10'h3a5, {ok, v})
    rc(ssp_pkg::A_CTRL, 8'h8a, "tx done");
    `CHK("irq on", 1'b1, irq)
    wr(ssp_pkg::A_IMASK, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    wr(ssp_pkg::A_IST, 8'h02);
    wr(ssp_pkg::A_IMASK, 8'h02);
    `CHK("irq cleared", 1'b0, irq)
    rc(ssp_pkg::A_CTRL, 8'h8a, "tx kept");
  endtask
  task automatic t_rx;
    wr(ssp_pkg::A_IMASK, 8'h01);
    rxc(8'h00, 8'h90, 9'h13c, 9, 64, 8'h95, 8'h3c);
    `CHK("irq rx", 1'b1, irq)
    wr(ssp_pkg::A_IST, 8'h01);
  endtask
  task automatic t_mp;
    rxc(8'h00, 8'hb0, 9'h05a, 9, 64, 8'hb0, 8'h3c);
    rxc(8'h00, 8'hb0, 9'h166, 9, 64, 8'hb5, 8'h66);
  endtask
  task automatic t_dbl;
    rxc(8'h01, 8'h90, 9'h1c3, 9, 32, 8'h95, 8'hc3);
  endtask
  task automatic t_m1;
    rxc(8'h00, 8'h70, 9'h022, 8, 64, 8'h75, 8'h22);
    // Ninth bit low lands on the stop slot
    rxc(8'h00, 8'h70, 9'h055, 9, 64, 8'h70, 8'h22);
    rxc(8'h02, 8'h50, 9'h0e7, 8, 32, 8'h55, 8'he7);
  endtask
  task automatic t_m0;
    logic [7:0] v;
    wr(ssp_pkg::A_CTRL, 8'h00);
    wr(ssp_pkg::A_DATA, 8'h96);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_out);
      @(negedge sys_clk);
      v[i] = rxd_out;
    end
    `CHK("sync data", 8'h96, v)
    repeat (8) @(posedge sys_clk);
    rc(ssp_pkg::A_CTRL, 8'h02, "sync done");
  endtask
  task automatic t_tx3;
    logic [8:0] v;
    logic ok;
    // Let the previous stop bit finish; a busy transmitter drops the write
    repeat (64) @(posedge sys_clk);
    wr(ssp_pkg::A_TIMING, 8'h04);
    wr(ssp_pkg::A_CTRL, 8'hc0);
    fork
      rem.recv(9, 32, v, ok);
      wr(ssp_pkg::A_DATA, 8'h3e);
    join
    `CHK("tx mode 3", 10'h23e, {ok, v})
    rc(ssp_pkg::A_CTRL, 8'hc2, "tx3 done");
    repeat (32) @(posedge sys_clk);
    wr(ssp_pkg::A_TIMING, 8'h00);
    wr(ssp_pkg::A_CTRL, 8'h40);
    fork
      rem.recv(8, 64, v, ok);
      wr(ssp_pkg::A_DATA, 8'hc9);
    join
    `CHK("tx mode 1", 10'h2c9, {ok, v})
    rc(ssp_pkg::A_CTRL, 8'h42, "tx1 done");
  endtask
  task automatic t_m0rx;
    fork
      rem.shift(8'h6b, 12);
      wr(ssp_pkg::A_CTRL, 8'h14);
    join
    rc(ssp_pkg::A_CTRL, 8'h15, "sync rx ctrl");
    rc(ssp_pkg::A_DATA, 8'h6b, "sync rx data");
    fork
      rem.shift(8'hd2, 4);
      wr(ssp_pkg::A_CTRL, 8'h34);
    join
    rc(ssp_pkg::A_CTRL, 8'h35, "fast rx ctrl");
    rc(ssp_pkg::A_DATA, 8'hd2, "fast rx data");
  endtask
  task automatic t_idle;
    wr(ssp_pkg::A_CTRL, 8'h00);
    wr(ssp_pkg::A_DATA, 8'h5a);
    // Freeze inside the high half of the first shift clock
    repeat (7) @(posedge sys_clk);
    idle <= 1'b1;
    repeat (120) @(posedge sys_clk);
    `CHK("idle clk", 1'b1, txd_out)
    `CHK("idle oe", 1'b1, rxd_oe)
    rc(ssp_pkg::A_CTRL, 8'h00, "idle hold");
    idle <= 1'b0;
    repeat (110) @(posedge sys_clk);
    rc(ssp_pkg::A_CTRL, 8'h02, "idle resume");
  endtask
  task automatic wrap_up;
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    tk = 1'b0;
    idle = 1'b0;
    rst_n = 1'b0;
    req = '0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_tx2();
    t_tx3();
    t_rx();
    t_mp();
    t_dbl();
    t_m1();
    t_m0();
    t_m0rx();
    t_idle();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end
endmodule
